// file: shared/lcdtp_pkg.sv
// Purpose: constants and carriers for the panel interface control block
// Assumes: indexed 8-bit host register access on one clock
// Notes:   horizontal index set holds total, blank start/end, sync start/end
package lcdtp_pkg;

   localparam logic [7:0] LCD_IF_CTRL_IDX = 8'h2c;
   localparam logic [7:0] LCD_IF_CTRL_RST = 8'h00;

   // crt controller indices that this block shadows
   localparam logic [7:0] HTOTAL_IDX  = 8'h00;
   localparam logic [7:0] HBSTART_IDX = 8'h02;
   localparam logic [7:0] HBEND_IDX   = 8'h03;
   localparam logic [7:0] HSSTART_IDX = 8'h04;
   localparam logic [7:0] HSEND_IDX   = 8'h05;
   localparam logic [7:0] VTOTAL_IDX  = 8'h06;
   localparam logic [7:0] VOVFL_IDX   = 8'h07;
   localparam logic [7:0] VRSTART_IDX = 8'h10;
   localparam logic [7:0] VREND_IDX   = 8'h11;
   localparam logic [7:0] VBSTART_IDX = 8'h15;
   localparam logic [7:0] VBEND_IDX   = 8'h16;

   // control field positions
   localparam int CLASS_HI   = 7;
   localparam int CLASS_LO   = 6;
   localparam int SHD_EN_BIT = 5;
   localparam int SHD_SEL_BIT = 4;
   localparam int VPROT_BIT  = 3;
   localparam int HPROT_BIT  = 2;
   localparam int LCLK_INV_BIT = 1;
   localparam int FS_INV_BIT = 0;
   localparam int STD_BOTH_BIT = 7;   // bit in vertical retrace end register

   localparam logic [7:0] VOVFL_PROT_MASK = 8'ha5;
   localparam logic [7:0] VREND_PROT_MASK = 8'h0f;

   localparam int HREG_N   = 5;
   localparam int VREG_N   = 6;
   localparam int HSLOT_W  = 3;
   localparam int VSLOT_W  = 3;
   localparam logic [HSLOT_W-1:0] HSLOT_NONE = 3'h7;
   localparam logic [VSLOT_W-1:0] VSLOT_NONE = 3'h7;

   typedef enum logic [1:0] {
      LCDTP_CLASS_MONO    = 2'b00,
      LCDTP_CLASS_RSVD    = 2'b01,
      LCDTP_CLASS_PASSIVE = 2'b10,
      LCDTP_CLASS_ACTIVE  = 2'b11
   } lcdtp_class_e;

   typedef enum logic [2:0] {
      LCDTP_PANEL_NONE        = 3'h0,
      LCDTP_PANEL_MONO_DUAL   = 3'h1,
      LCDTP_PANEL_MONO_SINGLE = 3'h2,
      LCDTP_PANEL_PM_DUAL     = 3'h3,
      LCDTP_PANEL_PM_SINGLE   = 3'h4,
      LCDTP_PANEL_ACTIVE      = 3'h5
   } lcdtp_panel_e;

   // host indexed access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] idx;
      logic [7:0] data;
   } lcdtp_req_s;

   // timing values presented to the panel timing generator
   typedef struct packed {
      logic [7:0] htotal;
      logic [7:0] hbstart;
      logic [7:0] hbend;
      logic [7:0] hsstart;
      logic [7:0] hsend;
      logic [7:0] vtotal;
      logic [7:0] vovfl;
      logic [7:0] vrstart;
      logic [7:0] vrend;
      logic [7:0] vbstart;
      logic [7:0] vbend;
   } lcdtp_timing_s;

endpackage

// file: tb/lcd_interface_timing_protect_bench.sv
// Purpose: register-level tests of the panel interface control block
// Assumes: host model drives all register traffic
// Notes:   reads return {valid, data}
`timescale 1ns/1ps
module lcd_interface_timing_protect_bench;
   logic                     clk = 1'b0;
   logic                     rst = 1'b1;
   lcdtp_pkg::lcdtp_req_s    req;
   logic [7:0]               rdata;
   logic                     rvalid;
   logic                     pen = 1'b0;
   logic                     mono = 1'b0;
   logic                     color = 1'b0;
   logic [1:0]               pfmt = 2'h0;
   logic                     lraw = 1'b0;
   logic                     fraw = 1'b0;
   logic                     lclk;
   logic                     fs;
   lcdtp_pkg::lcdtp_panel_e  ptype;
   logic [1:0]               pfo;
   lcdtp_pkg::lcdtp_timing_s tim;
   logic [8:0]               r;
   int                       errors = 0;
   int                       n_compared = 0;
   int                       cycles = 0;
   logic [1:0]               cls [6] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3};
   logic                     cfg [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
   logic [2:0]               typ [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
   always #2.5 clk = ~clk;
   lcdtp_ctrl dut (.core_clk_in(clk), .sys_rst_in(rst), .host_req_in(req),
      .host_rdata_out(rdata), .host_rvalid_out(rvalid), .panel_enable_in(pen),
      .mono_scan_config_in(mono), .color_scan_config_in(color),
      .pixel_format_config_in(pfmt), .line_clock_raw_in(lraw), .frame_start_raw_in(fraw),
      .panel_line_clock_out(lclk), .panel_frame_start_out(fs), .panel_type_out(ptype),
      .pixel_format_out(pfo), .timing_out(tim));
   lcdtp_host_model host (.core_clk_in(clk), .host_req_out(req), .rdata_in(rdata),
      .rvalid_in(rvalid));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // run normally ends near 140 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      host.rd(8'h2c, r); chk(r, 9'h100);
      host.rd(8'h01, r); chk(r[8], 1'b0);
      for (int i = 0; i < 6; i++) begin
         host.wr(8'h2c, {cls[i], 6'h00});
         @(posedge clk) begin mono <= cfg[i]; color <= cfg[i]; pfmt <= i[1:0]; end
         settle();
         chk({6'h0, ptype}, {6'h0, typ[i]});
         chk({7'h0, pfo}, {7'h0, i[1:0]});
      end
      host.wr(8'h2c, 8'h03);
      @(posedge clk) begin lraw <= 1'b1; fraw <= 1'b0; end
      settle();
      chk({7'h0, lclk, fs}, 9'h001);
      host.wr(8'h2c, 8'h00);
      settle();
      chk({7'h0, lclk, fs}, 9'h002);
      host.wr(8'h00, 8'h11);
      settle();
      chk({1'b0, tim.htotal}, 9'h011);
      host.rd(8'h00, r); chk(r, 9'h111);
      host.wr(8'h2c, 8'h20);
      host.wr(8'h00, 8'h22);
      host.rd(8'h00, r); chk(r, 9'h122);
      host.wr(8'h2c, 8'h00);
      host.rd(8'h00, r); chk(r, 9'h111);
      host.wr(8'h2c, 8'h30);
      host.rd(8'h00, r); chk(r, 9'h100);
      host.wr(8'h11, 8'h80);
      host.wr(8'h00, 8'h33);
      host.wr(8'h2c, 8'h20);
      host.rd(8'h00, r); chk(r, 9'h122);
      host.wr(8'h2c, 8'h00);
      host.rd(8'h00, r); chk(r, 9'h133);
      host.wr(8'h2c, 8'h30);
      host.rd(8'h00, r); chk(r, 9'h133);
      host.wr(8'h11, 8'h00);
      @(posedge clk) pen <= 1'b1;
      host.wr(8'h2c, 8'h04);
      host.wr(8'h02, 8'h44);
      host.rd(8'h02, r); chk(r, 9'h100);
      @(posedge clk) pen <= 1'b0;
      host.wr(8'h02, 8'h44);
      host.rd(8'h02, r); chk(r, 9'h144);
      host.wr(8'h2c, 8'h00);
      host.wr(8'h06, 8'h55);
      settle();
      chk({1'b0, tim.vtotal}, 9'h055);
      host.wr(8'h2c, 8'h08);
      host.wr(8'h06, 8'h66);
      host.wr(8'h07, 8'hff);
      host.rd(8'h06, r); chk(r, 9'h166);
      settle();
      chk({1'b0, tim.vtotal}, 9'h055);
      chk({1'b0, tim.vovfl}, 9'h05a);
      report_and_stop();
   end
endmodule // lcd_interface_timing_protect_bench
bind lcdtp_ctrl lcdtp_ctrl_assertions u_chk (.core_clk_in(core_clk_in),
   .sys_rst_in(sys_rst_in), .host_req_in(host_req_in), .host_rdata_out(host_rdata_out),
   .host_rvalid_out(host_rvalid_out), .mono_scan_config_in(mono_scan_config_in),
   .color_scan_config_in(color_scan_config_in),
   .pixel_format_config_in(pixel_format_config_in), .line_clock_raw_in(line_clock_raw_in),
   .frame_start_raw_in(frame_start_raw_in), .panel_line_clock_out(panel_line_clock_out),
   .panel_frame_start_out(panel_frame_start_out), .panel_type_out(panel_type_out),
   .pixel_format_out(pixel_format_out));

// file: tb/lcdtp_ctrl_assertions.sv
// Purpose: port-level checks for the panel interface control block
// Assumes: control register mirrored from host writes to index 0x2c
// Notes:   type and invert checks lean on that mirror
`timescale 1ns/1ps
module lcdtp_ctrl_assertions (
   input  wire logic                     core_clk_in,
   input  wire logic                     sys_rst_in,
   input  wire lcdtp_pkg::lcdtp_req_s    host_req_in,
   input  wire logic [7:0]               host_rdata_out,
   input  wire logic                     host_rvalid_out,
   input  wire logic                     mono_scan_config_in,
   input  wire logic                     color_scan_config_in,
   input  wire logic [1:0]               pixel_format_config_in,
   input  wire logic                     line_clock_raw_in,
   input  wire logic                     frame_start_raw_in,
   input  wire logic                     panel_line_clock_out,
   input  wire logic                     panel_frame_start_out,
   input  wire lcdtp_pkg::lcdtp_panel_e  panel_type_out,
   input  wire logic [1:0]               pixel_format_out
);
   logic [7:0] ctrl_q;
   logic [1:0] live_q;
   wire        rd_ctrl = host_req_in.rd && host_req_in.idx == lcdtp_pkg::LCD_IF_CTRL_IDX;
   wire        lclk_inv = ctrl_q[1];
   wire        fs_inv = ctrl_q[0];
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_q <= 8'h00;
      end else if (host_req_in.wr && host_req_in.idx == lcdtp_pkg::LCD_IF_CTRL_IDX) begin
         ctrl_q <= host_req_in.data;
      end
   end
   // pipeline checks wait two edges so $past never sees reset-time values
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         live_q <= 2'h0;
      end else begin
         live_q <= {live_q[0], 1'b1};
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////////////////////////////////////////////
   AST_RVALID_CAUSE: assert property (host_rvalid_out |-> $past(host_req_in.rd))
      else $error("read valid without a read");
   AST_CTRL_READ: assert property (rd_ctrl |=> host_rvalid_out && host_rdata_out == $past(ctrl_q))
      else $error("control read back wrong");
   AST_UNKNOWN_READ: assert property (host_req_in.rd && host_req_in.idx == 8'h01 |=>
      !host_rvalid_out)
      else $error("unknown index answered");
   AST_LCLK_INV: assert property (live_q[1] |->
      panel_line_clock_out == ($past(line_clock_raw_in) ^ $past(lclk_inv)))
      else $error("line clock polarity wrong");
   AST_FS_INV: assert property (live_q[1] |->
      panel_frame_start_out == ($past(frame_start_raw_in) ^ $past(fs_inv)))
      else $error("frame start polarity wrong");
   AST_PIXFMT: assert property (live_q[1] |->
      pixel_format_out == $past(pixel_format_config_in))
      else $error("pixel format not passed on");
   AST_ACTIVE: assert property (ctrl_q[7:6] == 2'b11 |=>
      panel_type_out == lcdtp_pkg::LCDTP_PANEL_ACTIVE)
      else $error("active class not reported");
   AST_MONO: assert property (ctrl_q[7:6] == 2'b00 |=> panel_type_out ==
      ($past(mono_scan_config_in) ? lcdtp_pkg::LCDTP_PANEL_MONO_SINGLE
                                  : lcdtp_pkg::LCDTP_PANEL_MONO_DUAL))
      else $error("mono scan type wrong");
   AST_PASSIVE: assert property (ctrl_q[7:6] == 2'b10 |=> panel_type_out ==
      ($past(color_scan_config_in) ? lcdtp_pkg::LCDTP_PANEL_PM_DUAL
                                   : lcdtp_pkg::LCDTP_PANEL_PM_SINGLE))
      else $error("passive scan type wrong");
   cover property (rd_ctrl ##1 host_rvalid_out);
   cover property (lclk_inv && line_clock_raw_in);
   cover property (ctrl_q[7:6] == 2'b10 && color_scan_config_in);
endmodule // lcdtp_ctrl_assertions

// file: tb/lcdtp_host_model.sv
// Purpose: host software issuing indexed register accesses
// Assumes: one-cycle strobes, read answer one cycle later
// Notes:   released index and data lines show the inverse of the last value
`timescale 1ns/1ps
module lcdtp_host_model (
   input  wire logic                   core_clk_in,
   output lcdtp_pkg::lcdtp_req_s       host_req_out,
   input  wire logic [7:0]             rdata_in,
   input  wire logic                   rvalid_in
);
   initial host_req_out = '0;
   // class 01 is never issued by the callers of this host
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      @(posedge core_clk_in);
      host_req_out <= '{wr: 1'b1, rd: 1'b0, idx: idx, data: data};
      @(posedge core_clk_in);
      host_req_out <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: ~data};
   endtask
   task automatic rd(input logic [7:0] idx, output logic [8:0] got);
      @(posedge core_clk_in);
      host_req_out <= '{wr: 1'b0, rd: 1'b1, idx: idx, data: 8'h5a};
      @(posedge core_clk_in);
      host_req_out <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: 8'ha5};
      #1;
      got = {rvalid_in, rdata_in};
   endtask
endmodule // lcdtp_host_model

// file: verilog/lcdtp_ctrl.sv
`timescale 1ns/1ps
// Purpose: panel interface control register with timing shadow steering
// Assumes: host gives one-cycle indexed read/write strobes on core_clk_in
// Notes:   read data valid one cycle after the read strobe

////////////////////////////////////////////////////////////////////////////////
module lcdtp_ctrl (
   input  wire logic                     core_clk_in,
   input  wire logic                     sys_rst_in,
   input  wire lcdtp_pkg::lcdtp_req_s    host_req_in,
   output logic      [7:0]               host_rdata_out,
   output logic                          host_rvalid_out,
   input  wire logic                     panel_enable_in,
   input  wire logic                     mono_scan_config_in,
   input  wire logic                     color_scan_config_in,
   input  wire logic [1:0]               pixel_format_config_in,
   input  wire logic                     line_clock_raw_in,
   input  wire logic                     frame_start_raw_in,
   output logic                          panel_line_clock_out,
   output logic                          panel_frame_start_out,
   output lcdtp_pkg::lcdtp_panel_e       panel_type_out,
   output logic      [1:0]               pixel_format_out,
   output lcdtp_pkg::lcdtp_timing_s      timing_out
);

   ////////////////////////////////////////////////////////////////////////////
   // index decode

   function automatic logic [2:0] hslot(input logic [7:0] idx);
      unique case (idx)
         lcdtp_pkg::HTOTAL_IDX:  hslot = 3'h0;
         lcdtp_pkg::HBSTART_IDX: hslot = 3'h1;
         lcdtp_pkg::HBEND_IDX:   hslot = 3'h2;
         lcdtp_pkg::HSSTART_IDX: hslot = 3'h3;
         lcdtp_pkg::HSEND_IDX:   hslot = 3'h4;
         default:                hslot = lcdtp_pkg::HSLOT_NONE;
      endcase
   endfunction

   function automatic logic [2:0] vslot(input logic [7:0] idx);
      unique case (idx)
         lcdtp_pkg::VTOTAL_IDX:  vslot = 3'h0;
         lcdtp_pkg::VOVFL_IDX:   vslot = 3'h1;
         lcdtp_pkg::VRSTART_IDX: vslot = 3'h2;
         lcdtp_pkg::VREND_IDX:   vslot = 3'h3;
         lcdtp_pkg::VBSTART_IDX: vslot = 3'h4;
         lcdtp_pkg::VBEND_IDX:   vslot = 3'h5;
         default:                vslot = lcdtp_pkg::VSLOT_NONE;
      endcase
   endfunction

   // one word out of a bank's parallel view; slot is valid whenever it is used
   function automatic logic [7:0] hword(input logic [lcdtp_pkg::HREG_N*8-1:0] w,
                                        input logic [2:0]                     s);
      hword = w[int'(s)*8 +: 8];
   endfunction

   // per-slot mask of bits frozen by vertical protection
   function automatic logic [7:0] vmask(input logic [2:0] s);
      unique case (s)
         3'h1:    vmask = lcdtp_pkg::VOVFL_PROT_MASK;
         3'h3:    vmask = lcdtp_pkg::VREND_PROT_MASK;
         default: vmask = 8'hff;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // control register

   logic [7:0] ctrl_q;
   logic       wr, rd;
   logic [7:0] idx, wdata;
   logic [2:0] hs, vs;
   logic       hit_h, hit_v, hit_ctrl;

   assign wr       = host_req_in.wr;
   assign rd       = host_req_in.rd;
   assign idx      = host_req_in.idx;
   assign wdata    = host_req_in.data;
   assign hs       = hslot(idx);
   assign vs       = vslot(idx);
   assign hit_h    = (hs != lcdtp_pkg::HSLOT_NONE);
   assign hit_v    = (vs != lcdtp_pkg::VSLOT_NONE);
   assign hit_ctrl = (idx == lcdtp_pkg::LCD_IF_CTRL_IDX);

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_q <= lcdtp_pkg::LCD_IF_CTRL_RST;
      end else if (wr && hit_ctrl) begin
         ctrl_q <= wdata;
      end
   end

   logic shd_en, shd_sel, vprot, hprot;
   assign shd_en  = ctrl_q[lcdtp_pkg::SHD_EN_BIT];
   assign shd_sel = ctrl_q[lcdtp_pkg::SHD_SEL_BIT];
   assign vprot   = ctrl_q[lcdtp_pkg::VPROT_BIT];
   assign hprot   = ctrl_q[lcdtp_pkg::HPROT_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // vertical registers: effective copy and host-visible shadow copy

   logic [7:0] vreg_eff_q [lcdtp_pkg::VREG_N];
   logic [7:0] vreg_shd_q [lcdtp_pkg::VREG_N];
   logic       std_both;

   // protected bits keep last pre-protect value; unprotected bits follow
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < lcdtp_pkg::VREG_N; i++) begin
            vreg_eff_q[i] <= 8'h00;
         end
      end else if (wr && hit_v) begin
         if (!vprot) begin
            vreg_eff_q[vs] <= wdata;
         end else begin
            vreg_eff_q[vs] <= (vreg_eff_q[vs] & vmask(vs)) | (wdata & ~vmask(vs));
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < lcdtp_pkg::VREG_N; i++) begin
            vreg_shd_q[i] <= 8'h00;
         end
      end else if (wr && hit_v) begin
         vreg_shd_q[vs] <= wdata;
      end
   end

   // host view: shadow takes every write, protected or not, so it is the read source
   assign std_both = vreg_shd_q[vslot(lcdtp_pkg::VREND_IDX)][lcdtp_pkg::STD_BOTH_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // horizontal registers: standard set plus two shadow sets

   logic       std_we, full_we, half_we, h_blocked;
   logic [lcdtp_pkg::HREG_N*8-1:0] std_w, full_w, half_w;

   assign h_blocked = panel_enable_in && hprot;

   always_comb begin
      std_we  = 1'b0;
      full_we = 1'b0;
      half_we = 1'b0;
      if (wr && hit_h && !h_blocked) begin
         if (!shd_en) begin
            std_we = 1'b1;
         end else begin
            std_we  = std_both;
            full_we = !shd_sel;
            half_we = shd_sel;
         end
      end
   end

   lcdtp_regbank #(.DEPTH(lcdtp_pkg::HREG_N), .ADDR_W(lcdtp_pkg::HSLOT_W)) u_std (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .we_in       (std_we),
      .waddr_in    (hs),
      .wdata_in    (wdata),
      .raddr_in    (hs),
      .rdata_out   (),
      .words_out   (std_w)
   );

   lcdtp_regbank #(.DEPTH(lcdtp_pkg::HREG_N), .ADDR_W(lcdtp_pkg::HSLOT_W)) u_full (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .we_in       (full_we),
      .waddr_in    (hs),
      .wdata_in    (wdata),
      .raddr_in    (hs),
      .rdata_out   (),
      .words_out   (full_w)
   );

   lcdtp_regbank #(.DEPTH(lcdtp_pkg::HREG_N), .ADDR_W(lcdtp_pkg::HSLOT_W)) u_half (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .we_in       (half_we),
      .waddr_in    (hs),
      .wdata_in    (wdata),
      .raddr_in    (hs),
      .rdata_out   (),
      .words_out   (half_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read path: parallel bank view picked at the strobe, so read data leave a flop

   logic [lcdtp_pkg::HREG_N*8-1:0] h_eff;
   assign h_eff = !shd_en ? std_w : (shd_sel ? half_w : full_w);

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         host_rdata_out <= 8'h00;
      end else begin
         host_rdata_out <= 8'h00;
         if (rd && hit_h) begin
            host_rdata_out <= hword(h_eff, hs);
         end else if (rd && hit_v) begin
            host_rdata_out <= vreg_shd_q[vs];
         end else if (rd && hit_ctrl) begin
            host_rdata_out <= ctrl_q;
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         host_rvalid_out <= 1'b0;
      end else begin
         host_rvalid_out <= rd && (hit_h || hit_v || hit_ctrl);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // panel class decode and output polarity

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         panel_type_out   <= lcdtp_pkg::LCDTP_PANEL_NONE;
         pixel_format_out <= 2'h0;
      end else begin
         pixel_format_out <= pixel_format_config_in;
         unique case (lcdtp_pkg::lcdtp_class_e'(ctrl_q[lcdtp_pkg::CLASS_HI:lcdtp_pkg::CLASS_LO]))
            lcdtp_pkg::LCDTP_CLASS_MONO: panel_type_out <= mono_scan_config_in ?
               lcdtp_pkg::LCDTP_PANEL_MONO_SINGLE : lcdtp_pkg::LCDTP_PANEL_MONO_DUAL;
            lcdtp_pkg::LCDTP_CLASS_PASSIVE: panel_type_out <= color_scan_config_in ?
               lcdtp_pkg::LCDTP_PANEL_PM_DUAL : lcdtp_pkg::LCDTP_PANEL_PM_SINGLE;
            lcdtp_pkg::LCDTP_CLASS_ACTIVE: panel_type_out <= lcdtp_pkg::LCDTP_PANEL_ACTIVE;
            // reserved class simply reports no panel
            lcdtp_pkg::LCDTP_CLASS_RSVD: panel_type_out <= lcdtp_pkg::LCDTP_PANEL_NONE;
         endcase
      end
   end

   // one flop of delay on both strobes keeps their mutual timing
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         panel_line_clock_out  <= 1'b0;
         panel_frame_start_out <= 1'b0;
      end else begin
         panel_line_clock_out  <= line_clock_raw_in ^ ctrl_q[lcdtp_pkg::LCLK_INV_BIT];
         panel_frame_start_out <= frame_start_raw_in ^ ctrl_q[lcdtp_pkg::FS_INV_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timing presented to the generator

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         timing_out <= '0;
      end else begin
         timing_out <= {h_eff[7:0], h_eff[15:8], h_eff[23:16], h_eff[31:24],
                        h_eff[39:32], vreg_eff_q[0], vreg_eff_q[1], vreg_eff_q[2],
                        vreg_eff_q[3], vreg_eff_q[4], vreg_eff_q[5]};
      end
   end

endmodule // lcdtp_ctrl

// file: verilog/lcdtp_regbank.sv
`timescale 1ns/1ps
// Purpose: small bank of 8-bit timing registers with registered read port
// Assumes: one write port and one read port on the same clock
// Notes:   all words also exposed in parallel for the timing generator
module lcdtp_regbank #(
   parameter int DEPTH  = 5,
   parameter int ADDR_W = 3
) (
   input  wire logic                   core_clk_in,
   input  wire logic                   sys_rst_in,
   input  wire logic                   we_in,
   input  wire logic [ADDR_W-1:0]      waddr_in,
   input  wire logic [7:0]             wdata_in,
   input  wire logic [ADDR_W-1:0]      raddr_in,
   output logic      [7:0]             rdata_out,
   output logic      [DEPTH*8-1:0]     words_out
);

   logic [7:0] mem_q [DEPTH];

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else if (we_in && (int'(waddr_in) < DEPTH)) begin
         mem_q[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_out <= 8'h00;
      end else if (int'(raddr_in) < DEPTH) begin
         rdata_out <= mem_q[raddr_in];
      end else begin
         rdata_out <= 8'h00;
      end
   end

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         words_out[i*8 +: 8] = mem_q[i];
      end
   end

endmodule // lcdtp_regbank
